// >>> logic/charge_seq_defines.svh
// timing counts, field codes and thresholds for the four-slot charge sequencer
// assumes a 125 MHz clock; included by bare name from the timebase, sequencer and peak store files
`ifndef CHARGE_SEQ_DEFINES_SVH
`define CHARGE_SEQ_DEFINES_SVH

`define CLOCK_MHZ          125
`define LAMP_TICK_MS       160
`define TICKS_PER_SLOT     3
`define BLINK_PERIOD_TICKS 6
`define CYCLE_CS           192
`define HOLDOFF_MIN        4
`define FLAT_MIN           16
`define HOLDOFF_CYCLES     (`HOLDOFF_MIN * 6000 / `CYCLE_CS)
`define FLAT_CYCLES        (`FLAT_MIN * 6000 / `CYCLE_CS)
`define DELTA_MV           2
`define SLOT_COUNT         4
`define LEVEL_W            12
`define FAST_SKIP_CODE     4'hF

`endif

// >>> logic/charge_seq_pkg.sv
// types shared by the charge sequencer files
// assumes nothing of its surroundings
package charge_seq_pkg;

   typedef enum logic [5:0] {
      ST_PRESENCE  = 6'b00_0001,
      ST_PRECHARGE = 6'b00_0010,
      ST_FAST      = 6'b00_0100,
      ST_TOPOFF    = 6'b00_1000,
      ST_MAINT     = 6'b01_0000,
      ST_FAULT     = 6'b10_0000
   } slot_state_e;

   typedef enum logic [1:0] {
      display_pattern_a = 2'h0,
      display_pattern_b = 2'h1,
      display_pattern_c = 2'h2
   } display_mode_e;

endpackage : charge_seq_pkg

// >>> logic/charge_timebase.sv
// slot and blink timebase: 0.16 s ticks, three ticks a slot, slots 0..3 in turn
// assumes a free-running clock; reset is synchronous
`timescale 1ns/10ps
`include "charge_seq_defines.svh"
module charge_timebase
   import charge_seq_pkg::*;
#(
   parameter int TICK_CYCLES = `LAMP_TICK_MS * 1000 * `CLOCK_MHZ
) (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       reset,
   // timing outputs
   output logic [1:0]      slot_idx,
   output logic            slot_end,
   output logic [2:0]      blink_phase
);
   logic [24:0] tick_cnt;
   logic [1:0]  sub;
   logic        tick_end;

   // last cycle of a tick and of a slot
   assign tick_end = (tick_cnt == 25'(TICK_CYCLES - 1));
   assign slot_end = tick_end && (sub == 2'(`TICKS_PER_SLOT - 1));

   // slot timing never depends on cell state, so slots stay undisturbed
   always_ff @(posedge clock) begin
      if (reset) begin
         tick_cnt    <= '0;
         sub         <= '0;
         slot_idx    <= '0;
         blink_phase <= '0;
      end else begin
         tick_cnt <= tick_end ? '0 : tick_cnt + 25'h000_0001;
         if (tick_end) begin
            sub         <= slot_end ? '0 : sub + 2'h1;
            slot_idx    <= slot_end ? slot_idx + 2'h1 : slot_idx;
            blink_phase <= (blink_phase == 3'(`BLINK_PERIOD_TICKS - 1)) ?
                           '0 : blink_phase + 3'h1;
         end
      end
   end
endmodule : charge_timebase

// >>> logic/four_slot_cell_charge_sequencer.sv
// per-slot charge state machines, round-robin gate drive and status lamps
// assumes comparator pins arrive asynchronously; level and timeout are on this clock
`timescale 1ns/10ps
`include "charge_seq_defines.svh"
module four_slot_cell_charge_sequencer
   import charge_seq_pkg::*;
#(
   parameter int TICK_CYCLES = `LAMP_TICK_MS * 1000 * `CLOCK_MHZ
) (
   // clock and reset
   input  wire logic                clock,
   input  wire logic                reset,
   // per-slot cell comparators, bit n is slot n
   input  wire logic [3:0]          cell_sense_present,
   input  wire logic [3:0]          cell_sense_above_low,
   input  wire logic [3:0]          cell_above_open_max,
   input  wire logic [3:0]          cell_above_loaded_max,
   // temperature comparators
   input  wire logic                temp_sense_a_in_window,
   input  wire logic                temp_sense_a_at_stop,
   input  wire logic                temp_sense_b_in_window,
   input  wire logic                temp_sense_b_at_stop,
   // mode pins
   input  wire logic                timeout_set_input_floating,
   input  wire logic [1:0]          display_pattern_select,
   // same-clock measurement and programmed fast timeout in 1.92 s cycles
   input  wire logic [`LEVEL_W-1:0] cell_level_mv,
   input  wire logic [15:0]         charge_timeout_cycles,
   // open-drain charge gates
   output logic [3:0]               charge_gate_n_out,
   output logic [3:0]               charge_gate_n_oe,
   // open-drain status lamps
   output logic [3:0]               status_lamp_out,
   output logic [3:0]               status_lamp_oe
);
   localparam int SYNC_W = 23;
   logic [SYNC_W-1:0]   sync_raw;
   logic [SYNC_W-1:0]   sync_s1;
   logic [SYNC_W-1:0]   sync_s2;
   logic [SYNC_W-1:0]   sync_s3;
   logic [SYNC_W-1:0]   sync_stable;
   logic [3:0]          present;
   logic [3:0]          above_low;
   logic [3:0]          open_max;
   logic [3:0]          loaded_max;
   logic                win_a;
   logic                stop_a;
   logic                win_b;
   logic                stop_b;
   logic                suspend;
   display_mode_e       disp_mode;
   logic [1:0]          slot_idx;
   logic                slot_end;
   logic [2:0]          blink_phase;
   logic [`LEVEL_W-1:0] peak_rd;
   logic [3:0]          pk_we;
   logic [`LEVEL_W-1:0] pk_wd [`SLOT_COUNT];
   logic [3:0]          next_gate;
   logic [3:0]          next_lamp;

   // duty pattern of the owning slot's gate for its phase
   function automatic logic gate_duty(input slot_state_e st, input logic [4:0] cyc);
      case (st)
         ST_FAST:      gate_duty = (cyc[3:0] != `FAST_SKIP_CODE);
         ST_PRECHARGE: gate_duty = (cyc[1:0] == 2'h0);
         ST_TOPOFF:    gate_duty = (cyc[1:0] == 2'h0);
         ST_MAINT:     gate_duty = (cyc == 5'h00);
         default:      gate_duty = 1'b0;
      endcase
   endfunction : gate_duty
   // lamp drive: 1 pulls the lamp low (lit)
   function automatic logic lamp_drive(input slot_state_e st, input display_mode_e m,
                                       input logic [2:0] ph);
      logic long_on;
      logic half_on;
      logic fast_on;
      long_on = (ph < 3'h5);
      half_on = (ph < 3'h3);
      fast_on = !ph[0];
      case (st)
         ST_PRECHARGE, ST_FAST, ST_TOPOFF:
            lamp_drive = (m == display_pattern_c) ? long_on : 1'b1;
         ST_MAINT:
            lamp_drive = (m == display_pattern_a) ? long_on : (m == display_pattern_c);
         ST_FAULT:
            lamp_drive = (m == display_pattern_a) ? half_on : fast_on;
         default:
            lamp_drive = 1'b0;
      endcase
   endfunction : lamp_drive
   // pin synchroniser: three stages, a change counts once stages two and three agree
   assign sync_raw = {cell_sense_present, cell_sense_above_low, cell_above_open_max,
                      cell_above_loaded_max, temp_sense_a_in_window, temp_sense_a_at_stop,
                      temp_sense_b_in_window, temp_sense_b_at_stop,
                      timeout_set_input_floating, display_pattern_select};
   always_ff @(posedge clock) begin
      if (reset) begin
         sync_s1     <= '0;
         sync_s2     <= '0;
         sync_s3     <= '0;
         sync_stable <= '0;
      end else begin
         sync_s1     <= sync_raw;
         sync_s2     <= sync_s1;
         sync_s3     <= sync_s2;
         sync_stable <= (~(sync_s2 ^ sync_s3) & sync_s3) | ((sync_s2 ^ sync_s3) & sync_stable);
      end
   end

   // named views of the filtered pins
   assign present    = sync_stable[22:19];
   assign above_low  = sync_stable[18:15];
   assign open_max   = sync_stable[14:11];
   assign loaded_max = sync_stable[10:7];
   assign win_a      = sync_stable[6];
   assign stop_a     = sync_stable[5];
   assign win_b      = sync_stable[4];
   assign stop_b     = sync_stable[3];
   assign suspend    = sync_stable[2];
   assign disp_mode  = sync_stable[1] ? display_pattern_c :
                       (sync_stable[0] ? display_pattern_b : display_pattern_a);
   charge_timebase #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_timebase (
      .clock       (clock),
      .reset       (reset),
      .slot_idx    (slot_idx),
      .slot_end    (slot_end),
      .blink_phase (blink_phase)
   );
   peak_store u_peaks (
      .clock      (clock),
      .reset      (reset),
      .write_en   (|pk_we),
      .write_addr (slot_idx),
      .write_data (pk_wd[slot_idx]),
      .read_addr  (slot_idx),
      .read_data  (peak_rd)
   );
   // one independent machine per slot
   for (genvar i = 0; i < `SLOT_COUNT; i++) begin : g_slot
      slot_state_e         st;
      slot_state_e         next_st;
      logic [4:0]          cyc;
      logic [4:0]          next_cyc;
      logic [15:0]         tmr;
      logic [15:0]         next_tmr;
      logic [9:0]          flat;
      logic [9:0]          next_flat;
      logic [6:0]          hold;
      logic [6:0]          next_hold;
      logic                eval;
      logic                temp_win;
      logic                temp_stop;
      logic                gate_on;
      logic                measure;
      logic                new_peak;
      logic                dropped;
      logic                over_loaded;
      logic                off_bad;
      logic                enter_fast;
      logic [`LEVEL_W-1:0] drop;

      // decisions for this slot are taken on the last cycle of its own slot
      assign eval        = slot_end && (slot_idx == 2'(i)) && !suspend;
      assign temp_win    = (i < 2) ? win_a : win_b;
      assign temp_stop   = (i < 2) ? stop_a : stop_b;
      assign gate_on     = charge_gate_n_oe[i];
      assign measure     = (st == ST_FAST) && (cyc[3:0] == `FAST_SKIP_CODE) &&
                           (hold >= 7'(`HOLDOFF_CYCLES));
      assign drop        = peak_rd - cell_level_mv;
      assign new_peak    = measure && (cell_level_mv > peak_rd);
      assign dropped     = measure && (peak_rd > cell_level_mv) &&
                           (drop >= `LEVEL_W'(`DELTA_MV));
      assign over_loaded = gate_on && loaded_max[i];
      assign off_bad     = !gate_on && (open_max[i] || !above_low[i]);
      assign enter_fast  = (st == ST_PRECHARGE) && (next_st == ST_FAST);
      assign pk_we[i]    = eval && present[i] && (enter_fast || new_peak);
      assign pk_wd[i]    = enter_fast ? '0 : cell_level_mv;

      // next phase; suspend and removal outrank everything else
      always_comb begin
         next_st   = st;
         next_cyc  = cyc;
         next_tmr  = tmr;
         next_flat = flat;
         next_hold = hold;
         if (suspend || (eval && !present[i])) begin
            next_st   = ST_PRESENCE;
            next_cyc  = '0;
            next_tmr  = '0;
            next_flat = '0;
            next_hold = '0;
         end else if (eval) begin
            next_cyc = cyc + 5'h01;
            unique case (st)
               ST_PRESENCE: begin
                  next_cyc = '0;
                  if (!open_max[i]) next_st = ST_PRECHARGE;
               end
               ST_PRECHARGE: begin
                  if (over_loaded || temp_stop) begin
                     next_st = ST_FAULT;
                  end else if (above_low[i] && temp_win) begin
                     next_st   = ST_FAST;
                     next_tmr  = '0;
                     next_flat = '0;
                     next_hold = '0;
                  end
               end
               ST_FAST: begin
                  next_tmr  = tmr + 16'h0001;
                  next_hold = (hold >= 7'(`HOLDOFF_CYCLES)) ? hold : hold + 7'h01;
                  next_flat = new_peak ? '0 : flat + 10'h001;
                  if (temp_stop) begin
                     next_st = ST_MAINT;
                  end else if (over_loaded || off_bad) begin
                     next_st = ST_FAULT;
                  end else if (dropped || (flat >= 10'(`FLAT_CYCLES)) ||
                               (tmr >= charge_timeout_cycles)) begin
                     next_st  = ST_TOPOFF;
                     next_tmr = '0;
                  end
               end
               ST_TOPOFF: begin
                  next_tmr = tmr + 16'h0001;
                  if (over_loaded) begin
                     next_st = ST_FAULT;
                  end else if (tmr >= {1'b0, charge_timeout_cycles[15:1]}) begin
                     next_st = ST_MAINT;
                  end
               end
               ST_MAINT: begin
                  if (over_loaded) next_st = ST_FAULT;
               end
               ST_FAULT: begin
                  next_cyc = cyc;
               end
            endcase
         end
      end

      always_ff @(posedge clock) begin
         if (reset) begin
            st   <= ST_PRESENCE;
            cyc  <= '0;
            tmr  <= '0;
            flat <= '0;
            hold <= '0;
         end else begin
            st   <= next_st;
            cyc  <= next_cyc;
            tmr  <= next_tmr;
            flat <= next_flat;
            hold <= next_hold;
         end
      end

      // gate dropped one cycle before the slot ends, so slots never overlap
      assign next_gate[i] = !suspend && (slot_idx == 2'(i)) && !slot_end &&
                            gate_duty(st, cyc);
      assign next_lamp[i] = present[i] && lamp_drive(st, disp_mode, blink_phase);
   end

   // pins drive low only; the enable carries the state
   always_ff @(posedge clock) begin
      if (reset) begin
         charge_gate_n_out <= '0;
         charge_gate_n_oe  <= '0;
         status_lamp_out   <= '0;
         status_lamp_oe    <= '0;
      end else begin
         charge_gate_n_out <= '0;
         charge_gate_n_oe  <= next_gate;
         status_lamp_out   <= '0;
         status_lamp_oe    <= next_lamp;
      end
   end

   // checks
   property p_one_gate;
      @(posedge clock) disable iff (reset) $onehot0(charge_gate_n_oe);
   endproperty
   a_one_gate: assert property (p_one_gate) else $error("two gates active");
   property p_gate_owner;
      @(posedge clock) disable iff (reset)
         (|charge_gate_n_oe) |-> charge_gate_n_oe[$past(slot_idx)];
   endproperty
   a_gate_owner: assert property (p_gate_owner) else $error("gate outside slot");
   property p_suspend_gates;
      @(posedge clock) disable iff (reset) suspend |=> (charge_gate_n_oe == 4'h0);
   endproperty
   a_suspend_gates: assert property (p_suspend_gates) else $error("gate in suspend");
   property p_suspend_reset;
      @(posedge clock) disable iff (reset)
         suspend |=> (g_slot[0].st == ST_PRESENCE) && (g_slot[3].st == ST_PRESENCE) &&
                     (g_slot[1].tmr == 16'h0000);
   endproperty
   a_suspend_reset: assert property (p_suspend_reset) else $error("suspend no reset");
   property p_removal;
      @(posedge clock) disable iff (reset)
         (g_slot[0].eval && !present[0] && g_slot[2].st != ST_PRESENCE && !g_slot[2].eval)
         |=> (g_slot[0].st == ST_PRESENCE) && (g_slot[2].st == $past(g_slot[2].st));
   endproperty
   a_removal: assert property (p_removal) else $error("removal reset wrong");
   property p_loaded_fault;
      @(posedge clock) disable iff (reset)
         (g_slot[0].eval && present[0] && g_slot[0].over_loaded &&
          g_slot[0].st inside {ST_TOPOFF, ST_MAINT}) |=> (g_slot[0].st == ST_FAULT);
   endproperty
   a_loaded_fault: assert property (p_loaded_fault) else $error("no fault on max");
   property p_skip_slot;
      @(posedge clock) disable iff (reset)
         charge_gate_n_oe[0] |->
            !($past(g_slot[0].st) == ST_FAST && $past(g_slot[0].cyc[3:0]) == 4'hF);
   endproperty
   a_skip_slot: assert property (p_skip_slot) else $error("gate in skip slot");
   property p_topoff_half;
      @(posedge clock) disable iff (reset)
         (g_slot[0].eval && present[0] && !g_slot[0].over_loaded &&
          g_slot[0].st == ST_TOPOFF && g_slot[0].tmr >= {1'b0, charge_timeout_cycles[15:1]})
         |=> (g_slot[0].st == ST_MAINT);
   endproperty
   a_topoff_half: assert property (p_topoff_half) else $error("top-off timeout");
   property p_fast_entry;
      @(posedge clock) disable iff (reset)
         $rose(g_slot[0].st == ST_FAST) |-> (g_slot[0].tmr == 16'h0000) && $past(win_a);
   endproperty
   a_fast_entry: assert property (p_fast_entry) else $error("bad fast entry");
   property p_stop_maint;
      @(posedge clock) disable iff (reset)
         (g_slot[2].eval && present[2] && g_slot[2].st == ST_FAST && stop_b)
         |=> (g_slot[2].st == ST_MAINT);
   endproperty
   a_stop_maint: assert property (p_stop_maint) else $error("stop temp ignored");
   c_fast:   cover property (@(posedge clock) g_slot[0].st == ST_FAST);
   c_topoff: cover property (@(posedge clock) g_slot[1].st == ST_TOPOFF);
   c_maint:  cover property (@(posedge clock) g_slot[2].st == ST_MAINT);
   c_fault:  cover property (@(posedge clock) g_slot[3].st == ST_FAULT);
endmodule : four_slot_cell_charge_sequencer

// >>> logic/peak_store.sv
// four-word store of each slot's peak cell voltage, registered read
// assumes one write per cycle at most
`timescale 1ns/10ps
`include "charge_seq_defines.svh"
module peak_store
   import charge_seq_pkg::*;
(
   // clock and reset
   input  wire logic                clock,
   input  wire logic                reset,
   // write port
   input  wire logic                write_en,
   input  wire logic [1:0]          write_addr,
   input  wire logic [`LEVEL_W-1:0] write_data,
   // read port
   input  wire logic [1:0]          read_addr,
   output logic [`LEVEL_W-1:0]      read_data
);
   logic [`LEVEL_W-1:0] mem [`SLOT_COUNT];

   // storage needs no reset: a word is cleared on every fast-charge entry
   always_ff @(posedge clock) begin
      if (write_en) begin
         mem[write_addr] <= write_data;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         read_data <= '0;
      end else begin
         read_data <= mem[read_addr];
      end
   end
endmodule : peak_store

// >>> testbench/cell_bank_model.sv
// cells behind the four slots, as comparator levels
// assumes the bench sets each cell in mV, 0 meaning empty slot
`timescale 1ns/10ps
module cell_bank_model (
   // cell voltages, slot n in bits 12n+11..12n
   input  wire logic [47:0] cell_mv,
   // comparator results
   output logic [3:0]       present,
   output logic [3:0]       above_low,
   output logic [3:0]       open_max,
   output logic [3:0]       loaded_max
);
   // fixed thresholds 1.00 V, 1.65 V, 1.75 V
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         present[i]    = cell_mv[12*i +: 12] != 12'h000;
         above_low[i]  = cell_mv[12*i +: 12] >= 12'h03E8;
         open_max[i]   = cell_mv[12*i +: 12] > 12'h0672;
         loaded_max[i] = cell_mv[12*i +: 12] > 12'h06D6;
      end
   end
endmodule : cell_bank_model

// >>> testbench/four_slot_cell_charge_sequencer_test.sv
// scenario bench for the charge sequencer, slot of 12 clocks
// assumes TICK_CYCLES of 4, so one round of four slots is 48 clocks
`timescale 1ns/10ps
module four_slot_cell_charge_sequencer_test;
   import charge_seq_pkg::*;
   logic        clock = 0;
   logic        reset = 1;
   logic [47:0] cell_mv = '0;
   logic        susp = 0;
   logic        stop_b = 0;
   logic [1:0]  disp_sel = 2'h0;
   logic [11:0] level = 12'h04B0;
   logic [3:0]  pres, low, omax, lmax, g_out, g_oe, l_out, l_oe;
   int          fails = 0;
   int          checks_done = 0;
   logic [7:0]  n;
   always #4 clock = ~clock;
   cell_bank_model cell_bank_model_inst (.cell_mv(cell_mv), .present(pres),
      .above_low(low), .open_max(omax), .loaded_max(lmax));
   four_slot_cell_charge_sequencer #(.TICK_CYCLES(4)) four_slot_cell_charge_sequencer_inst (
      .clock(clock), .reset(reset), .cell_sense_present(pres),
      .cell_sense_above_low(low), .cell_above_open_max(omax),
      .cell_above_loaded_max(lmax), .temp_sense_a_in_window(1'b1),
      .temp_sense_a_at_stop(1'b0), .temp_sense_b_in_window(1'b1),
      .temp_sense_b_at_stop(stop_b), .timeout_set_input_floating(susp),
      .display_pattern_select(disp_sel), .cell_level_mv(level),
      .charge_timeout_cycles(16'h4000), .charge_gate_n_out(g_out),
      .charge_gate_n_oe(g_oe), .status_lamp_out(l_out), .status_lamp_oe(l_oe));
   task automatic end_sim;
      if (fails == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim
   task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
   endtask : cmp
   task automatic rounds(input int r);
      repeat (48 * r) @(posedge clock);
   endtask : rounds
   // counts charge pulses of one slot; gates must never overlap
   task automatic pulses(input int s, input int r, output logic [7:0] c);
      logic prev;
      prev = 0;
      c = 0;
      repeat (48 * r) begin
         @(negedge clock);
         if (g_oe[s] === 1'b1 && !prev) c++;
         prev = g_oe[s];
         if (!$onehot0(g_oe) || g_out !== 4'h0) cmp("gate overlap", 8'h00, 8'h01);
      end
   endtask : pulses
   task automatic set_cell(input int s, input logic [11:0] mv);
      @(posedge clock);
      cell_mv[12*s +: 12] <= mv;
   endtask : set_cell
   task automatic s_precharge;
      set_cell(0, 12'h0384);
      rounds(3);
      pulses(0, 16, n);
      cmp("precharge pulses", 8'h04, n);
   endtask : s_precharge
   task automatic s_fast;
      set_cell(0, 12'h04B0);
      rounds(3);
      pulses(0, 16, n);
      cmp("fast pulses", 8'h0F, n);
      cmp("lamp charging", 8'h01, {7'h0, l_oe[0]});
      cmp("lamp empty", 8'h00, {7'h0, l_oe[1]});
      cmp("lamp drive level", 8'h00, {4'h0, l_out});
   endtask : s_fast
   task automatic s_removal;
      set_cell(2, 12'h0384);
      rounds(3);
      set_cell(0, 12'h000);
      rounds(2);
      pulses(0, 4, n);
      cmp("removed slot pulses", 8'h00, n);
      pulses(2, 16, n);
      cmp("other slot pulses", 8'h04, n);
   endtask : s_removal
   task automatic s_fault;
      set_cell(2, 12'h0708);
      rounds(6);
      pulses(2, 8, n);
      cmp("fault pulses", 8'h00, n);
   endtask : s_fault
   // suspend drops gates, then charging restarts from pre-charge
   task automatic s_suspend;
      set_cell(0, 12'h04B0);
      rounds(5);
      @(posedge clock);
      susp <= 1'b1;
      repeat (10) @(posedge clock);
      pulses(0, 4, n);
      cmp("suspend pulses", 8'h00, n);
      @(posedge clock);
      susp <= 1'b0;
      set_cell(0, 12'h0384);
      rounds(3);
      pulses(0, 16, n);
      cmp("restart pulses", 8'h04, n);
   endtask : s_suspend
   // stop temperature on the second sensor: fast to maintenance, pre-charge to fault
   task automatic s_temp;
      set_cell(2, 12'h04B0);
      rounds(4);
      @(posedge clock);
      stop_b <= 1'b1;
      set_cell(3, 12'h0384);
      rounds(4);
      pulses(2, 32, n);
      cmp("maintenance pulses", 8'h01, n);
      pulses(3, 8, n);
      cmp("stop precharge pulses", 8'h00, n);
      pulses(0, 8, n);
      cmp("other sensor pulses", 8'h02, n);
      @(posedge clock);
      disp_sel <= 2'h1;
      repeat (8) @(negedge clock);
      cmp("lamp maint pattern b", 8'h00, {7'h0, l_oe[2]});
      @(posedge clock);
      disp_sel <= 2'h2;
      repeat (8) @(negedge clock);
      cmp("lamp maint pattern c", 8'h01, {7'h0, l_oe[2]});
   endtask : s_temp
   // peak taken after hold-off, then a 3 mV fall ends fast charge
   task automatic s_delta;
      set_cell(0, 12'h04B0);
      rounds(150);
      @(posedge clock);
      level <= 12'h04AD;
      rounds(18);
      pulses(0, 16, n);
      cmp("top-off pulses", 8'h04, n);
   endtask : s_delta
   initial begin
      repeat (12) @(posedge clock);
      reset <= 1'b0;
      @(negedge clock);
      cmp("gates after reset", 8'h00, {4'h0, g_oe});
      s_precharge();
      s_fast();
      s_removal();
      s_fault();
      s_suspend();
      s_temp();
      s_delta();
      end_sim();
   end
   // watchdog well past the roughly 17000 clocks the scenarios need
   initial begin
      repeat (40000) @(posedge clock);
      fails++;
      end_sim();
   end
endmodule : four_slot_cell_charge_sequencer_test
